/* test/imp_core_model.sv */
// core and interrupt-source stand-in on the block's core side
// assumes bench commands are one-cycle pulses on the same clock
`timescale 1ns/10ps
`default_nettype none

module imp_core_model (
  input wire logic i_clk,
  input wire logic i_irq_req,
  input wire logic i_halt,
  input wire logic [6:0] i_pend,
  input wire logic i_ack_cmd,
  input wire logic i_slow,
  input wire logic i_reti_cmd,
  input wire logic i_done_cmd,
  output logic [6:0] o_pending,
  output logic o_ack,
  output logic o_reti,
  output logic o_done
);
  logic [2:0] wait_cnt;

  // quiet core at time zero
  initial begin
    wait_cnt = 3'h0;
    o_pending = 7'h00;
    o_ack = 1'b0;
    o_reti = 1'b0;
    o_done = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // vectoring picks up the request promptly or late, and only while it is shown
  always @(posedge i_clk) begin
    o_pending <= i_pend;
    o_ack <= 1'b0;
    o_reti <= i_reti_cmd;
    o_done <= i_done_cmd & ~i_halt; // a halted core finishes nothing
    if (i_ack_cmd) begin
      wait_cnt <= i_slow ? 3'h4 : 3'h1;
    end else if (wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
      o_ack <= (wait_cnt == 3'h1) & i_irq_req;
    end
  end
endmodule

`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the interrupt mask, priority and power block
// assumes a register port on AXI4-Lite and a core model on the core side
`timescale 1ns/10ps
`default_nettype none
`include "imp_consts.svh"

module testbench;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [9:0] aw_addr = 10'h000, ar_addr = 10'h000;
  logic [31:0] w_data = 32'h0, r_data;
  logic aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
  logic usb_ev = 1'b0, sup_lvl = 1'b0, slow = 1'b0;
  logic ack_c = 1'b0, reti_c = 1'b0, done_c = 1'b0;
  logic [6:0] pend_c = 7'h00, pend_w;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, ack, reti, done;
  logic irq_req, irq_high, halt, osc_stop, osc_susp, mcd_rst;
  logic [1:0] b_resp, r_resp, rs;
  logic [2:0] irq_id;
  logic [31:0] d;
  logic [7:0] idx_t [5], rst_t [5], ff_t [5], msk_i [7], msk_on [7];
  int msk_b [7];
  int miscompares = 0, cmp_count = 0, i, n;

  always #12.5 clk = ~clk;

  imp_irq_power dut_u (.I_CLK(clk), .I_RESETN(rst_n), .I_AWADDR(aw_addr), .I_AWVALID(aw_v),
    .O_AWREADY(aw_rdy), .I_WDATA(w_data), .I_WSTRB(4'hF), .I_WVALID(w_v), .O_WREADY(w_rdy),
    .O_BRESP(b_resp), .O_BVALID(b_v), .I_BREADY(b_rdy), .I_ARADDR(ar_addr), .I_ARVALID(ar_v),
    .O_ARREADY(ar_rdy), .O_RDATA(r_data), .O_RRESP(r_resp), .O_RVALID(r_v), .I_RREADY(r_rdy),
    .I_SRC_PENDING(pend_w), .I_IRQ_ACK(ack), .I_IRQ_RETI(reti), .I_INSTR_DONE(done),
    .I_USB_EVENT(usb_ev), .I_SUPPLY_LEVEL(sup_lvl), .O_IRQ_REQ(irq_req), .O_IRQ_ID(irq_id),
    .O_IRQ_HIGH(irq_high), .O_CPU_HALT(halt), .O_OSC_STOP(osc_stop),
    .O_OSC_SUSPEND(osc_susp), .O_MCD_RESET(mcd_rst));

  imp_core_model core_u (.i_clk(clk), .i_irq_req(irq_req), .i_halt(halt), .i_pend(pend_c),
    .i_ack_cmd(ack_c), .i_slow(slow), .i_reti_cmd(reti_c), .i_done_cmd(done_c),
    .o_pending(pend_w), .o_ack(ack), .o_reti(reti), .o_done(done));

  ////////////////////////////////////////////////////////////////////////////////
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // sample off the clock edge so registered outputs have landed
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles: handshakes judged from values seen half a cycle before the edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic a_s, w_s, b_s, ok;
    ok = 1'b0;
    @(posedge clk);
    aw_addr <= {idx, 2'b00};
    w_data <= {24'h0, v};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'b1;
    for (int k = 0; k < 100 && !ok; k++) begin
      @(negedge clk);
      {a_s, w_s, b_s, rs} = {aw_rdy, w_rdy, b_v, b_resp};
      @(posedge clk);
      if (a_s) aw_v <= 1'b0;
      if (w_s) w_v <= 1'b0;
      if (b_s) begin
        b_rdy <= 1'b0;
        ok = 1'b1;
      end
    end
    chk("write response", 1, ok);
  endtask

  task automatic rd(input logic [7:0] idx);
    logic a_s, r_s, ok;
    ok = 1'b0;
    @(posedge clk);
    ar_addr <= {idx, 2'b00};
    ar_v <= 1'b1;
    r_rdy <= 1'b1;
    for (int k = 0; k < 100 && !ok; k++) begin
      @(negedge clk);
      {a_s, r_s, d, rs} = {ar_rdy, r_v, r_data, r_resp};
      @(posedge clk);
      if (a_s) ar_v <= 1'b0;
      if (r_s) begin
        r_rdy <= 1'b0;
        ok = 1'b1;
      end
    end
    chk("read response", 1, ok);
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
    rd(idx);
    chk($sformatf("reg %h", idx), {24'h0, exp}, d);
  endtask

  // core-side strobes: one cycle each, then a gap
  task automatic cmd(input logic [2:0] c);
    @(posedge clk);
    {ack_c, reti_c, done_c} <= c;
    @(posedge clk);
    {ack_c, reti_c, done_c} <= 3'b000;
  endtask

  task automatic irq(input logic [6:0] p, input logic r, input logic [2:0] id);
    @(posedge clk);
    pend_c <= p;
    settle(8);
    chk("irq request", r, irq_req);
    if (r) chk("irq source", id, irq_id);
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    #1000000;
    miscompares++;
    tally_and_finish;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    idx_t = '{`IMP_IDX_IE, `IMP_IDX_IP, `IMP_IDX_EIE_ONE, `IMP_IDX_EIE_TWO, `IMP_IDX_EIP_ONE};
    rst_t = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    ff_t = '{8'h9F, 8'h9F, 8'h02, 8'h01, 8'h02};
    msk_i = '{8'hA8, 8'hA8, 8'hA8, 8'hA8, 8'hA8, 8'hE6, 8'hE7};
    msk_on = '{8'h9F, 8'h9F, 8'h9F, 8'h9F, 8'h9F, 8'h02, 8'h01};
    msk_b = '{0, 1, 2, 3, 4, 1, 0};
    do_reset;
    // reset values, then reserved bits across full and empty writes
    for (i = 0; i < 5; i++) begin
      rc(idx_t[i], rst_t[i]);
      wr(idx_t[i], 8'hFF);
      rc(idx_t[i], ff_t[i]);
      wr(idx_t[i], 8'h00);
      rc(idx_t[i], rst_t[i]);
    end
    rc(`IMP_IDX_PWR, 8'h00);
    wr(`IMP_IDX_PWR, 8'hFC);
    chk("write resp", 0, rs);
    rc(`IMP_IDX_PWR, 8'hFC);
    rd(8'h10);
    chk("unmapped resp", 2, rs);
    chk("unmapped data", 0, d);
    wr(8'h10, 8'h00);
    chk("unmapped write resp", 2, rs);
    // each source passes alone, then its own mask blocks it
    wr(`IMP_IDX_IE, 8'h9F);
    wr(`IMP_IDX_EIE_ONE, 8'h02);
    wr(`IMP_IDX_EIE_TWO, 8'h01);
    for (i = 0; i < 7; i++) begin
      irq(7'h01 << i, 1, 3'(i));
      wr(msk_i[i], msk_on[i] & ~(8'h01 << msk_b[i]));
      irq(7'h01 << i, 0, 0);
      wr(msk_i[i], msk_on[i]);
    end
    wr(`IMP_IDX_IE, 8'h1F);
    irq(7'h7F, 0, 0);
    wr(`IMP_IDX_IE, 8'h9F);
    // fixed order inside one tier, then each priority bit lifts its source
    for (i = 0; i < 7; i++) irq(7'h7F << i, 1, 3'(i));
    for (i = 0; i < 5; i++) begin
      wr(`IMP_IDX_IP, 8'h01 << i);
      irq(7'h7F, 1, 3'(i));
      chk("high tier", 1, irq_high);
    end
    wr(`IMP_IDX_IP, 8'h00);
    wr(`IMP_IDX_EIP_ONE, 8'h02);
    irq(7'h7F, 1, 3'h5);
    chk("usb high", 1, irq_high);
    wr(`IMP_IDX_EIP_ONE, 8'h00);
    // nesting: high preempts low, nothing preempts high
    wr(`IMP_IDX_IP, 8'h01);
    irq(7'h08, 1, 3'h3);
    cmd(3'b100);
    irq(7'h08, 0, 0);
    irq(7'h09, 1, 3'h0);
    slow <= 1'b1;
    cmd(3'b100);
    wr(`IMP_IDX_IP, 8'h11);
    irq(7'h19, 0, 0);
    cmd(3'b010);
    irq(7'h19, 1, 3'h0);
    irq(7'h00, 0, 0);
    cmd(3'b010);
    slow <= 1'b0;
    // idle: halts after the instruction, masked source keeps it halted
    wr(`IMP_IDX_IP, 8'h00);
    wr(`IMP_IDX_IE, 8'h88);
    wr(`IMP_IDX_PWR, 8'hFD);
    cmd(3'b001);
    settle(3);
    chk("idle halt", 1, halt);
    rc(`IMP_IDX_PWR, 8'hFC);
    rc(`IMP_IDX_STAT, 8'h01);
    irq(7'h10, 0, 0);
    chk("idle masked", 1, halt);
    irq(7'h08, 1, 3'h3);
    chk("idle wake", 0, halt);
    irq(7'h00, 0, 0);
    // stop: no interrupt wakes it, missing-clock reset ends it
    wr(`IMP_IDX_CTRL, 8'h01);
    wr(`IMP_IDX_PWR, 8'hFE);
    cmd(3'b001);
    settle(3);
    chk("stop halt", 1, halt);
    chk("stop osc", 1, osc_stop);
    irq(7'h08, 0, 0);
    chk("stop kept", 1, halt);
    for (n = 0; n < 5000 && mcd_rst !== 1'b1; n++) @(negedge clk);
    chk("mcd reset", 1, mcd_rst);
    chk("mcd late", 1, n > 3900);
    do_reset;
    settle(1);
    chk("reset osc", 0, osc_stop);
    chk("reset halt", 0, halt);
    rc(`IMP_IDX_IE, 8'h00);
    // suspend ends on supply match, then on a usb event
    pend_c <= 7'h00;
    wr(`IMP_IDX_CTRL, 8'h06);
    settle(3);
    chk("suspend", 1, osc_susp);
    @(posedge clk);
    sup_lvl <= 1'b1;
    settle(6);
    chk("supply wake", 0, osc_susp);
    wr(`IMP_IDX_CTRL, 8'h04);
    settle(6);
    chk("suspend held", 1, osc_susp);
    @(posedge clk);
    usb_ev <= 1'b1;
    settle(6);
    chk("usb wake", 0, osc_susp);
    tally_and_finish;
  end
endmodule

`default_nettype wire

/* verilog/imp_consts.svh */
// constants for the interrupt mask, priority and power-mode block
// assumes 8-bit register indices; byte address is four times the index
`ifndef IMP_CONSTS_SVH
`define IMP_CONSTS_SVH

// register indices
`define IMP_IDX_PWR 8'h87
`define IMP_IDX_IE 8'hA8
`define IMP_IDX_IP 8'hB8
`define IMP_IDX_EIE_ONE 8'hE6
`define IMP_IDX_EIE_TWO 8'hE7
`define IMP_IDX_EIP_ONE 8'hF6
`define IMP_IDX_CTRL 8'hC0
`define IMP_IDX_STAT 8'hC1

// reset values
`define IMP_RST_IE 8'h00
`define IMP_RST_IP 8'h80
`define IMP_RST_EXT 8'h00
`define IMP_RST_PWR 8'h00
`define IMP_RST_CTRL 8'h00

// writable bits of each register
`define IMP_WMASK_IE 8'h9F
`define IMP_WMASK_IP 8'h1F
`define IMP_WMASK_EIE_ONE 8'h02
`define IMP_WMASK_EIP_ONE 8'h02
`define IMP_WMASK_EIE_TWO 8'h01
`define IMP_WMASK_PWR 8'hFC
`define IMP_WMASK_CTRL 8'h03
// fixed read value of the unused priority bits
`define IMP_IP_FIXED 8'h80

// field positions
`define IMP_BIT_GIE 7
`define IMP_BIT_IDLE 0
`define IMP_BIT_STOP 1
`define IMP_BIT_USB 1
`define IMP_BIT_SUPPLY 0
`define IMP_BIT_MCD_EN 0
`define IMP_BIT_POL 1
`define IMP_BIT_SUSPEND 2

// missing clock timeout
`define IMP_MCD_TIMEOUT_US 100
`define IMP_CLK_MHZ 40
`define IMP_MCD_CYCLES (`IMP_MCD_TIMEOUT_US * `IMP_CLK_MHZ)

// bus responses
`define IMP_RESP_OKAY 2'h0
`define IMP_RESP_SLVERR 2'h2

`endif

/* verilog/imp_irq_power.sv */
// interrupt masking, two-tier priority arbitration and idle/stop/suspend control
// assumes pending flags and core strobes come from logic on I_CLK;
// usb event and supply level are pins and are synchronised here
//
// Local design decision: the AXI4-Lite register port.
`include "imp_consts.svh"
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RULE_01: global enable bit 7 blocks every source when zero, else masks apply.
// RULE_02: enable register at A8, reset zero, holds global and five source masks.
// RULE_03: enable bits 6 and 5 read zero and ignore writes.
// RULE_04: serial mask bit 4 passes serial requests when set.
// RULE_05: timer1 mask bit 3 passes timer1 overflow requests when set.
// RULE_06: external input one mask bit 2 passes its requests when set.
// RULE_07: priority bits 4..0 put their source in high tier when one.
// RULE_08: priority register at B8 resets to 80, top three bits read 100.
// RULE_09: extended enable one at E6 holds usb mask bit 1, rest zero.
// RULE_10: extended priority one at F6 holds usb priority bit 1, rest zero.
// RULE_11: extended enable two at E7 holds supply-level mask bit 0.
// RULE_12: idle halts core after the writing instruction; peripherals keep running.
// RULE_13: enabled request during idle clears idle and resumes the core.
// RULE_14: reset during idle runs the normal reset sequence.
// RULE_15: stop halts oscillator, core and interrupts after the writing instruction.
// RULE_16: stop ends only by reset; interrupts never wake it.
// RULE_17: enabled missing-clock detector resets the device out of stop.
// RULE_18: suspended oscillator stays halted until usb event or supply matches polarity.
// RULE_19: power control at 87: stop bit 1, idle bit 0 read zero, six flags.
// RULE_20: high requests preempt low handlers; high handlers are never preempted.
// RULE_21: equal tier order: ext0, timer0, ext1, timer1, serial, usb, supply.
// RULE_22: request needs pending, its mask and global enable; priority picks tier.
// RULE_23: registers update on the clock and take reset values on any reset.
module imp_irq_power #(
  parameter int ADDR_W = 10
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire imp_pkg::imp_src_type I_SRC_PENDING,
  input wire logic I_IRQ_ACK,
  input wire logic I_IRQ_RETI,
  input wire logic I_INSTR_DONE,
  input wire logic I_USB_EVENT,
  input wire logic I_SUPPLY_LEVEL,
  output logic O_IRQ_REQ,
  output imp_pkg::imp_id_type O_IRQ_ID,
  output logic O_IRQ_HIGH,
  output logic O_CPU_HALT,
  output logic O_OSC_STOP,
  output logic O_OSC_SUSPEND,
  output logic O_MCD_RESET
);
  import imp_pkg::*;

  localparam int MCD_CYC = `IMP_MCD_CYCLES;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic rst_meta_ff;
  logic rst_n;
  logic usb_meta_ff;
  logic usb_ff;
  logic sup_meta_ff;
  logic sup_ff;

  // reset asserts at once, releases two edges later
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // pins from outside the clock domain
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      usb_meta_ff <= 1'b0;
      usb_ff <= 1'b0;
      sup_meta_ff <= 1'b0;
      sup_ff <= 1'b0;
    end else begin
      usb_meta_ff <= I_USB_EVENT;
      usb_ff <= usb_meta_ff;
      sup_meta_ff <= I_SUPPLY_LEVEL;
      sup_ff <= sup_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave and register file

  logic aw_got_ff, nxt_aw_got;
  logic w_got_ff, nxt_w_got;
  logic [7:0] aw_idx_ff, nxt_aw_idx;
  logic [7:0] wdat_ff, nxt_wdat;
  logic wstb_ff, nxt_wstb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [7:0] rdat_ff, nxt_rdat;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [7:0] rd_idx_ff, nxt_rd_idx;
  logic [7:0] ie_ff, nxt_ie;
  logic [7:0] ip_ff, nxt_ip;
  logic [7:0] irq_enable_ext_one_ff, nxt_irq_enable_ext_one;
  logic [7:0] irq_enable_ext_two_ff, nxt_irq_enable_ext_two;
  logic [7:0] irq_priority_ext_one_ff, nxt_irq_priority_ext_one;
  logic [7:0] pwr_ff, nxt_pwr;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic idle_wr, stop_wr, susp_wr;
  logic do_wr;
  logic [7:0] stat;
  imp_pwr_type state_ff, nxt_state;
  logic susp_ff, nxt_susp;
  logic lo_act_ff, nxt_lo_act;
  logic hi_act_ff, nxt_hi_act;
  logic req_ff;

  // status view of the block's own state
  assign stat = {2'h0, req_ff, hi_act_ff, lo_act_ff, susp_ff,
                 state_ff == PWR_STOP, state_ff == PWR_IDLE};

  // a write needs both halves; either may arrive first
  assign do_wr = aw_got_ff && w_got_ff && !bvalid_ff;

  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_aw_idx = aw_idx_ff;
    nxt_wdat = wdat_ff;
    nxt_wstb = wstb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdat = rdat_ff;
    nxt_rresp = rresp_ff;
    nxt_rd_idx = rd_idx_ff;
    nxt_ie = ie_ff;
    nxt_ip = ip_ff;
    nxt_irq_enable_ext_one = irq_enable_ext_one_ff;
    nxt_irq_enable_ext_two = irq_enable_ext_two_ff;
    nxt_irq_priority_ext_one = irq_priority_ext_one_ff;
    nxt_pwr = pwr_ff;
    nxt_ctrl = ctrl_ff;
    idle_wr = 1'b0;
    stop_wr = 1'b0;
    susp_wr = 1'b0;
    if (I_AWVALID && O_AWREADY) begin
      nxt_aw_got = 1'b1;
      nxt_aw_idx = I_AWADDR[9:2];
    end
    if (I_WVALID && O_WREADY) begin
      nxt_w_got = 1'b1;
      nxt_wdat = I_WDATA[7:0];
      nxt_wstb = I_WSTRB[0];
    end
    if (bvalid_ff && I_BREADY) begin
      nxt_bvalid = 1'b0;
    end
    // only byte lane 0 carries data; other lanes are ignored
    if (do_wr) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = `IMP_RESP_OKAY;
      if (aw_idx_ff == `IMP_IDX_IE) begin
        if (wstb_ff) nxt_ie = wdat_ff & `IMP_WMASK_IE; // see RULE_02 RULE_03
      end else if (aw_idx_ff == `IMP_IDX_IP) begin
        if (wstb_ff) nxt_ip = wdat_ff & `IMP_WMASK_IP; // see RULE_07 RULE_08
      end else if (aw_idx_ff == `IMP_IDX_EIE_ONE) begin
        if (wstb_ff) nxt_irq_enable_ext_one = wdat_ff & `IMP_WMASK_EIE_ONE; // see RULE_09
      end else if (aw_idx_ff == `IMP_IDX_EIE_TWO) begin
        if (wstb_ff) nxt_irq_enable_ext_two = wdat_ff & `IMP_WMASK_EIE_TWO; // see RULE_11
      end else if (aw_idx_ff == `IMP_IDX_EIP_ONE) begin
        if (wstb_ff) nxt_irq_priority_ext_one = wdat_ff & `IMP_WMASK_EIP_ONE; // see RULE_10
      end else if (aw_idx_ff == `IMP_IDX_PWR) begin
        // mode bits act as strobes and are never stored
        if (wstb_ff) begin
          nxt_pwr = wdat_ff & `IMP_WMASK_PWR; // see RULE_19
          idle_wr = wdat_ff[`IMP_BIT_IDLE];
          stop_wr = wdat_ff[`IMP_BIT_STOP];
        end
      end else if (aw_idx_ff == `IMP_IDX_CTRL) begin
        if (wstb_ff) begin
          nxt_ctrl = wdat_ff & `IMP_WMASK_CTRL;
          susp_wr = wdat_ff[`IMP_BIT_SUSPEND];
        end
      end else if (aw_idx_ff != `IMP_IDX_STAT) begin
        nxt_bresp = `IMP_RESP_SLVERR;
      end
    end
    if (rvalid_ff && I_RREADY) begin
      nxt_rvalid = 1'b0;
    end
    if (I_ARVALID && O_ARREADY) begin
      nxt_rvalid = 1'b1;
      nxt_rd_idx = I_ARADDR[9:2];
      nxt_rresp = `IMP_RESP_OKAY;
      if (I_ARADDR[9:2] == `IMP_IDX_IE) begin
        nxt_rdat = ie_ff;
      end else if (I_ARADDR[9:2] == `IMP_IDX_IP) begin
        nxt_rdat = ip_ff | `IMP_IP_FIXED; // see RULE_08
      end else if (I_ARADDR[9:2] == `IMP_IDX_EIE_ONE) begin
        nxt_rdat = irq_enable_ext_one_ff;
      end else if (I_ARADDR[9:2] == `IMP_IDX_EIE_TWO) begin
        nxt_rdat = irq_enable_ext_two_ff;
      end else if (I_ARADDR[9:2] == `IMP_IDX_EIP_ONE) begin
        nxt_rdat = irq_priority_ext_one_ff;
      end else if (I_ARADDR[9:2] == `IMP_IDX_PWR) begin
        nxt_rdat = pwr_ff;
      end else if (I_ARADDR[9:2] == `IMP_IDX_CTRL) begin
        nxt_rdat = ctrl_ff;
      end else if (I_ARADDR[9:2] == `IMP_IDX_STAT) begin
        nxt_rdat = stat;
      end else begin
        nxt_rdat = 8'h00;
        nxt_rresp = `IMP_RESP_SLVERR;
      end
    end
  end

  // every register returns to its reset value on the released reset
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_idx_ff <= 8'h00;
      wdat_ff <= 8'h00;
      wstb_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `IMP_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdat_ff <= 8'h00;
      rresp_ff <= `IMP_RESP_OKAY;
      rd_idx_ff <= 8'h00;
      ie_ff <= `IMP_RST_IE; // see RULE_23
      ip_ff <= `IMP_RST_IP & `IMP_WMASK_IP;
      irq_enable_ext_one_ff <= `IMP_RST_EXT;
      irq_enable_ext_two_ff <= `IMP_RST_EXT;
      irq_priority_ext_one_ff <= `IMP_RST_EXT;
      pwr_ff <= `IMP_RST_PWR;
      ctrl_ff <= `IMP_RST_CTRL;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      aw_idx_ff <= nxt_aw_idx;
      wdat_ff <= nxt_wdat;
      wstb_ff <= nxt_wstb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdat_ff <= nxt_rdat;
      rresp_ff <= nxt_rresp;
      rd_idx_ff <= nxt_rd_idx;
      ie_ff <= nxt_ie;
      ip_ff <= nxt_ip;
      irq_enable_ext_one_ff <= nxt_irq_enable_ext_one;
      irq_enable_ext_two_ff <= nxt_irq_enable_ext_two;
      irq_priority_ext_one_ff <= nxt_irq_priority_ext_one;
      pwr_ff <= nxt_pwr;
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign O_AWREADY = !aw_got_ff;
  assign O_WREADY = !w_got_ff;
  assign O_BVALID = bvalid_ff;
  assign O_BRESP = bresp_ff;
  assign O_ARREADY = !rvalid_ff;
  assign O_RVALID = rvalid_ff;
  assign O_RDATA = {24'h000000, rdat_ff};
  assign O_RRESP = rresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // masking and two-tier arbitration

  imp_src_type mask, prio, eligible, hi_tier, lo_tier, pick;
  logic nxt_req, nxt_high;
  imp_id_type nxt_id, id_ff;
  logic high_ff;
  logic gie;

  assign gie = ie_ff[`IMP_BIT_GIE];
  // source order: ext0, timer0, ext1, timer1, serial, usb, supply
  assign mask = {irq_enable_ext_two_ff[`IMP_BIT_SUPPLY], irq_enable_ext_one_ff[`IMP_BIT_USB],
                 ie_ff[4:0]}; // see RULE_04 RULE_05 RULE_06
  // supply-level priority register is not provided, so that source stays low
  assign prio = {1'b0, irq_priority_ext_one_ff[`IMP_BIT_USB], ip_ff[4:0]}; // see RULE_07 RULE_10
  assign eligible = gie ? (I_SRC_PENDING & mask) : 7'h00; // see RULE_01 RULE_22
  assign hi_tier = eligible & prio;
  assign lo_tier = eligible & ~prio;

  always_comb begin
    nxt_req = 1'b0;
    nxt_high = 1'b0;
    nxt_id = 3'h0;
    pick = 7'h00;
    nxt_lo_act = lo_act_ff;
    nxt_hi_act = hi_act_ff;
    // high tier only while no high handler runs; low only when idle
    if (!hi_act_ff && hi_tier != 7'h00) begin
      pick = hi_tier; // see RULE_20
      nxt_high = 1'b1;
    end else if (!hi_act_ff && !lo_act_ff) begin
      pick = lo_tier;
    end
    // lowest index wins inside a tier
    for (int k = 6; k >= 0; k--) begin
      if (pick[k]) begin
        nxt_id = 3'(k); // see RULE_21
      end
    end
    // no request is raised from the idle or stop state; one may still show in the first halted cycle
    nxt_req = (pick != 7'h00) && (state_ff != PWR_IDLE) && (state_ff != PWR_STOP);
    if (!nxt_req) begin
      nxt_high = 1'b0;
    end
    // a return closes the innermost level first
    if (I_IRQ_RETI) begin
      if (hi_act_ff) nxt_hi_act = 1'b0;
      else nxt_lo_act = 1'b0;
    end
    if (I_IRQ_ACK && req_ff) begin
      if (high_ff) nxt_hi_act = 1'b1;
      else nxt_lo_act = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      req_ff <= 1'b0;
      id_ff <= 3'h0;
      high_ff <= 1'b0;
      lo_act_ff <= 1'b0;
      hi_act_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req;
      id_ff <= nxt_id;
      high_ff <= nxt_high;
      lo_act_ff <= nxt_lo_act;
      hi_act_ff <= nxt_hi_act;
    end
  end

  assign O_IRQ_REQ = req_ff;
  assign O_IRQ_ID = id_ff;
  assign O_IRQ_HIGH = high_ff;

  ////////////////////////////////////////////////////////////////////////////
  // idle, stop, suspend and missing-clock detector

  logic halt_ff, nxt_halt;
  logic oscstop_ff, nxt_oscstop;
  logic mcd_ff, nxt_mcd;
  logic [11:0] mcd_cnt_ff, nxt_mcd_cnt;
  logic wake_match;

  assign wake_match = usb_ff || (sup_ff == ctrl_ff[`IMP_BIT_POL]);

  always_comb begin
    nxt_state = state_ff;
    nxt_susp = susp_ff;
    nxt_mcd = mcd_ff;
    nxt_mcd_cnt = mcd_cnt_ff;
    case (state_ff)
      PWR_RUN: begin
        // stop wins if both bits are written together
        if (stop_wr) nxt_state = PWR_STOP_ARM;
        else if (idle_wr) nxt_state = PWR_IDLE_ARM;
      end
      PWR_IDLE_ARM: begin
        if (I_INSTR_DONE) nxt_state = PWR_IDLE; // see RULE_12
      end
      PWR_IDLE: begin
        if (eligible != 7'h00) nxt_state = PWR_RUN; // see RULE_13
      end
      PWR_STOP_ARM: begin
        if (I_INSTR_DONE) nxt_state = PWR_STOP; // see RULE_15
      end
      PWR_STOP: begin
        nxt_state = PWR_STOP; // see RULE_16 RULE_14
      end
      default: begin
        nxt_state = PWR_RUN;
      end
    endcase
    // clock loss is only modelled while stopped; the request is held to reset
    if (state_ff == PWR_STOP && ctrl_ff[`IMP_BIT_MCD_EN] && !mcd_ff) begin
      if (mcd_cnt_ff == 12'(MCD_CYC - 1)) nxt_mcd = 1'b1; // see RULE_17
      else nxt_mcd_cnt = mcd_cnt_ff + 12'h001;
    end else begin
      nxt_mcd_cnt = 12'h000;
    end
    // a wake condition already present ends suspend one cycle after it is entered
    if (susp_wr) nxt_susp = 1'b1;
    if (susp_ff && wake_match) nxt_susp = 1'b0; // see RULE_18
    nxt_halt = (nxt_state == PWR_IDLE) || (nxt_state == PWR_STOP);
    nxt_oscstop = nxt_state == PWR_STOP;
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= PWR_RUN; // see RULE_14
      susp_ff <= 1'b0;
      mcd_ff <= 1'b0;
      mcd_cnt_ff <= 12'h000;
      halt_ff <= 1'b0;
      oscstop_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      susp_ff <= nxt_susp;
      mcd_ff <= nxt_mcd;
      mcd_cnt_ff <= nxt_mcd_cnt;
      halt_ff <= nxt_halt;
      oscstop_ff <= nxt_oscstop;
    end
  end

  assign O_CPU_HALT = halt_ff;
  assign O_OSC_STOP = oscstop_ff;
  assign O_OSC_SUSPEND = susp_ff;
  assign O_MCD_RESET = mcd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_gie_blocks: assert property (@(posedge I_CLK) disable iff (!rst_n) // see RULE_01
    !gie |=> !O_IRQ_REQ) else $error("request issued with global enable clear");
  chk_ie_unused: assert property (@(posedge I_CLK) disable iff (!rst_n) // see RULE_03
    (O_RVALID && rd_idx_ff == `IMP_IDX_IE) |-> O_RDATA[6:5] == 2'h0)
    else $error("unused enable bits read nonzero");
  chk_ip_top: assert property (@(posedge I_CLK) disable iff (!rst_n) // see RULE_08
    (O_RVALID && rd_idx_ff == `IMP_IDX_IP) |-> O_RDATA[7:5] == 3'h4)
    else $error("unused priority bits not 100");
  chk_mask_gate: assert property (@(posedge I_CLK) disable iff (!rst_n) // see RULE_22
    O_IRQ_REQ |-> |(($past(eligible) >> O_IRQ_ID) & 7'h01)
      && (O_IRQ_HIGH == |(($past(prio) >> O_IRQ_ID) & 7'h01)))
    else $error("request from an ineligible source or wrong tier");
  chk_high_holds: assert property (@(posedge I_CLK) disable iff (!rst_n) // see RULE_20
    hi_act_ff |=> !O_IRQ_REQ) else $error("high handler preempted");
  chk_fixed_order: assert property (@(posedge I_CLK) disable iff (!rst_n) // see RULE_21
    O_IRQ_REQ |-> ($past(pick) & ((7'h01 << O_IRQ_ID) - 7'h01)) == 7'h00)
    else $error("lower-order source skipped");
  chk_idle_wait: assert property (@(posedge I_CLK) disable iff (!rst_n) // see RULE_12
    (state_ff == PWR_IDLE_ARM && !I_INSTR_DONE) |=> !O_CPU_HALT)
    else $error("halted before instruction end");
  chk_idle_wake: assert property (@(posedge I_CLK) disable iff (!rst_n) // see RULE_13
    (state_ff == PWR_IDLE && eligible != 7'h00) |=> !O_CPU_HALT ##1 O_IRQ_REQ [*1])
    else $error("idle not ended by enabled request");
  chk_stop_stays: assert property (@(posedge I_CLK) disable iff (!rst_n) // see RULE_16
    state_ff == PWR_STOP |=> (O_CPU_HALT && O_OSC_STOP && !O_IRQ_REQ))
    else $error("stop left without reset");
  chk_mcd_time: assert property (@(posedge I_CLK) disable iff (!rst_n) // see RULE_17
    $rose(O_MCD_RESET) |-> $past(mcd_cnt_ff) == 12'(MCD_CYC - 1))
    else $error("detector fired at wrong count");
  chk_susp_wake: assert property (@(posedge I_CLK) disable iff (!rst_n) // see RULE_18
    (O_OSC_SUSPEND && !wake_match) |=> O_OSC_SUSPEND)
    else $error("suspend ended without wake condition");
  chk_pwr_reads: assert property (@(posedge I_CLK) disable iff (!rst_n) // see RULE_19
    (O_RVALID && rd_idx_ff == `IMP_IDX_PWR) |-> O_RDATA[1:0] == 2'h0)
    else $error("mode select bits read nonzero");

endmodule

`default_nettype wire

/* verilog/imp_pkg.sv */
// types for the interrupt mask, priority and power-mode block
// assumes nothing beyond the constants header
package imp_pkg;
  typedef enum logic [2:0] {
    PWR_RUN,
    PWR_IDLE_ARM,
    PWR_IDLE,
    PWR_STOP_ARM,
    PWR_STOP
  } imp_pwr_type;
  typedef logic [6:0] imp_src_type;
  typedef logic [2:0] imp_id_type;
endpackage
